// [core/clk_out_cfg_pkg.sv]
// constants, field layout and register map of the clock output configuration block
//------------------------------------------------------------------------------
// Summary of operation
// [R1] output divider is {top[3:0], mid byte, low byte}, top part first
// [R2] phase code routes legs: 00 t/c, 01 t/t, 10 c/c, 11 c/t
// [R3] software writes drive strength 3'b111 as the recommended setting
// [R4] low six bits of the skew code give coarse delay in oscillator periods
// [R5] coarse delay spans 0 to 63 periods, equal to the code value
// [R6] two-bit fine code adds 0 to 3 steps of 30 ps
// [R7] format bit 4 extends fine code to three bits, 0 to 4 steps
// [R8] supply field bits 4:3: 00 is 1.8 V, 01 2.5 V, 10 3.3 V
// [R9] standard field bits 2:0 selects one of six driver types
// [R10] marker bits 7:6 read 01 or 10 once fuse memory is written
// [R11] termination bits 3:0 select external, pull, or single-ended leg modes
// [R12] software writes only listed standard, supply and termination codes
//------------------------------------------------------------------------------
package clk_out_cfg_pkg;

  //----------------------------------------------------------------------------
  // register indices; byte address is four times the index
  //----------------------------------------------------------------------------
  localparam logic [5:0] IDX_OUT3_FORMAT_CFG      = 6'h2d;
  localparam logic [5:0] IDX_OUT3_TERMINATION_CFG = 6'h2f;
  localparam logic [5:0] IDX_OUT4_DIVIDER_TOP     = 6'h30;
  localparam logic [5:0] IDX_OUT4_DIVIDER_MID     = 6'h31;
  localparam logic [5:0] IDX_OUT4_DIVIDER_LOW     = 6'h32;
  localparam logic [5:0] IDX_OUT4_PHASE_STRENGTH  = 6'h33;
  localparam logic [5:0] IDX_OUT4_DELAY_COARSE    = 6'h34;
  localparam int         ADDR_W                   = 8;

  //----------------------------------------------------------------------------
  // reset values and writable bit masks
  //----------------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE          = 8'h00;
  localparam logic [7:0] MASK_FORMAT       = 8'hdf;
  localparam logic [7:0] MASK_TERMINATION  = 8'h0f;
  localparam logic [7:0] MASK_DIVIDER_TOP  = 8'h0f;
  localparam logic [7:0] MASK_FULL         = 8'hff;
  localparam logic [7:0] MASK_PHASE_STR    = 8'hc7;

  //----------------------------------------------------------------------------
  // field positions
  //----------------------------------------------------------------------------
  localparam int FMT_MARKER_LSB = 6;
  localparam int FMT_FINE_EXT   = 4;
  localparam int FMT_SUPPLY_LSB = 3;
  localparam int FMT_STD_LSB    = 0;
  localparam int PH_SEL_LSB     = 6;
  localparam int PH_STR_LSB     = 0;
  localparam int DLY_FINE_LSB   = 6;
  localparam int DLY_COARSE_LSB = 0;

  //----------------------------------------------------------------------------
  // codes and timing figures
  //----------------------------------------------------------------------------
  localparam logic [2:0] STRENGTH_RECOMMENDED = 3'h7;
  localparam logic [2:0] FINE_STEPS_MAX       = 3'h4;
  localparam int         FINE_STEP_PS         = 30;
  localparam logic [3:0] TERM_EXTERNAL        = 4'h0;
  localparam logic [3:0] TERM_PULL_UP         = 4'h2;
  localparam logic [3:0] TERM_PULL_DOWN       = 4'h1;
  localparam logic [3:0] TERM_SE_TRUE         = 4'h4;
  localparam logic [3:0] TERM_SE_COMP         = 4'h8;
  localparam logic [3:0] TERM_SE_BOTH         = 4'hc;

  typedef enum logic [2:0] {
    STD_LVDS          = 3'h0,
    STD_LVPECL_CM     = 3'h1,
    STD_CML           = 3'h2,
    STD_HCSL          = 3'h3,
    STD_LVDS_BOOST    = 3'h4,
    STD_LVPECL_NO_CM  = 3'h5
  } output_standard_t;

  typedef enum logic [1:0] {
    SUPPLY_1V8 = 2'h0,
    SUPPLY_2V5 = 2'h1,
    SUPPLY_3V3 = 2'h2
  } output_supply_t;

endpackage : clk_out_cfg_pkg

// [core/leg_phase_router.sv]
// single-ended leg source selection from the phase code
`timescale 1ns/1ns
`default_nettype none
module leg_phase_router (
  input  wire logic [1:0] phase_sel,
  output logic            single_ended_true_leg,
  output logic            single_ended_comp_leg
);
  // 0 selects true_clock, 1 selects complement_clock
  always_comb
  begin
    unique case (phase_sel)
      2'h0:
      begin
        single_ended_true_leg = 1'b0; // see [R2]
        single_ended_comp_leg = 1'b1;
      end
      2'h1:
      begin
        single_ended_true_leg = 1'b0; // see [R2]
        single_ended_comp_leg = 1'b0;
      end
      2'h2:
      begin
        single_ended_true_leg = 1'b1; // see [R2]
        single_ended_comp_leg = 1'b1;
      end
      2'h3:
      begin
        single_ended_true_leg = 1'b1; // see [R2]
        single_ended_comp_leg = 1'b0;
      end
    endcase
  end
endmodule // leg_phase_router
`default_nettype wire

// [core/skew_decoder.sv]
// splits the output skew code into coarse periods and fine steps
`timescale 1ns/1ns
`default_nettype none
module skew_decoder (
  input  wire logic [7:0] output_skew_code,
  input  wire logic       fine_extend,
  output logic      [5:0] coarse_periods,
  output logic      [2:0] fine_steps,
  output logic      [6:0] fine_delay_ps
);
  logic [2:0] fine_code;

  // coarse delay equals the code value, 0 to 63 periods
  assign coarse_periods = output_skew_code[5:0]; // see [R4] see [R5]

  // the extension bit is the top bit of a three-bit code; codes above four
  // clamp so the fine delay never passes four steps
  always_comb
  begin
    fine_code = {fine_extend, output_skew_code[7:6]}; // see [R6] see [R7]
    if (fine_code > clk_out_cfg_pkg::FINE_STEPS_MAX)
      fine_steps = clk_out_cfg_pkg::FINE_STEPS_MAX; // see [R7]
    else
      fine_steps = fine_code; // see [R6]
    fine_delay_ps = 7'(fine_steps * clk_out_cfg_pkg::FINE_STEP_PS);
  end
endmodule // skew_decoder
`default_nettype wire

// [core/clk_out_cfg_regs.sv]
// apb register bank for two clock output channels and its decoded settings
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module clk_out_cfg_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [2:0]  output_standard_sel,
  output logic      [1:0]  output_supply_sel,
  output logic             fuse_written,
  output logic             term_pull_up,
  output logic             term_pull_down,
  output logic             se_true_en,
  output logic             se_comp_en,
  output logic      [19:0] output_divider,
  output logic             single_ended_true_leg,
  output logic             single_ended_comp_leg,
  output logic      [2:0]  se_drive_strength,
  output logic      [5:0]  coarse_periods,
  output logic      [2:0]  fine_steps,
  output logic      [6:0]  fine_delay_ps
);

  //----------------------------------------------------------------------------
  // storage
  //----------------------------------------------------------------------------
  logic [7:0] out3_format_cfg;
  logic [7:0] out3_termination_cfg;
  logic [7:0] out4_divider_top;
  logic [7:0] out4_divider_mid;
  logic [7:0] out4_divider_low;
  logic [7:0] out4_phase_strength;
  logic [7:0] out4_delay_coarse;

  //----------------------------------------------------------------------------
  // bus decode
  //----------------------------------------------------------------------------
  logic       setup_phase;
  logic       access_done;
  logic       wr_commit;
  logic       addr_aligned;
  logic [5:0] reg_idx;
  logic       hit;
  logic [7:0] rd_byte;
  logic [7:0] wr_byte;

  assign setup_phase  = psel && !penable;
  assign access_done  = psel && penable && pready;
  assign addr_aligned = (paddr[1:0] == 2'h0);
  assign reg_idx      = paddr[7:2];
  assign wr_byte      = pwdata[7:0];
  assign wr_commit    = access_done && pwrite && pstrb[0] && hit;

  // narrow registers sit in the low lane; upper lanes read zero
  always_comb
  begin
    hit     = addr_aligned;
    rd_byte = 8'h00;
    unique case (reg_idx)
      clk_out_cfg_pkg::IDX_OUT3_FORMAT_CFG:      rd_byte = out3_format_cfg;
      clk_out_cfg_pkg::IDX_OUT3_TERMINATION_CFG: rd_byte = out3_termination_cfg;
      clk_out_cfg_pkg::IDX_OUT4_DIVIDER_TOP:     rd_byte = out4_divider_top;
      clk_out_cfg_pkg::IDX_OUT4_DIVIDER_MID:     rd_byte = out4_divider_mid;
      clk_out_cfg_pkg::IDX_OUT4_DIVIDER_LOW:     rd_byte = out4_divider_low;
      clk_out_cfg_pkg::IDX_OUT4_PHASE_STRENGTH:  rd_byte = out4_phase_strength;
      clk_out_cfg_pkg::IDX_OUT4_DELAY_COARSE:    rd_byte = out4_delay_coarse;
      default:                                   hit     = 1'b0;
    endcase
  end

  //----------------------------------------------------------------------------
  // apb answer
  //----------------------------------------------------------------------------
  // the answer is prepared in the setup cycle so all three bus outputs come
  // from flops; costs nothing, access still ends on its first edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= setup_phase;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else if (setup_phase)
      pslverr <= !hit;
    else if (access_done)
      pslverr <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_phase && !pwrite && hit)
      prdata <= {24'h00_0000, rd_byte};
    else if (setup_phase)
      prdata <= 32'h0000_0000;
  end

  //----------------------------------------------------------------------------
  // register writes
  //----------------------------------------------------------------------------
  // the marker bits are ordinary storage; hardware never alters them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out3_format_cfg      <= clk_out_cfg_pkg::RST_BYTE;
      out3_termination_cfg <= clk_out_cfg_pkg::RST_BYTE;
      out4_divider_top     <= clk_out_cfg_pkg::RST_BYTE;
      out4_divider_mid     <= clk_out_cfg_pkg::RST_BYTE;
      out4_divider_low     <= clk_out_cfg_pkg::RST_BYTE;
      out4_phase_strength  <= clk_out_cfg_pkg::RST_BYTE;
      out4_delay_coarse    <= clk_out_cfg_pkg::RST_BYTE;
    end
    else if (wr_commit)
    begin
      unique case (reg_idx)
        clk_out_cfg_pkg::IDX_OUT3_FORMAT_CFG:
          out3_format_cfg <= wr_byte & clk_out_cfg_pkg::MASK_FORMAT;
        clk_out_cfg_pkg::IDX_OUT3_TERMINATION_CFG:
          out3_termination_cfg <= wr_byte & clk_out_cfg_pkg::MASK_TERMINATION;
        clk_out_cfg_pkg::IDX_OUT4_DIVIDER_TOP:
          out4_divider_top <= wr_byte & clk_out_cfg_pkg::MASK_DIVIDER_TOP;
        clk_out_cfg_pkg::IDX_OUT4_DIVIDER_MID:
          out4_divider_mid <= wr_byte & clk_out_cfg_pkg::MASK_FULL;
        clk_out_cfg_pkg::IDX_OUT4_DIVIDER_LOW:
          out4_divider_low <= wr_byte & clk_out_cfg_pkg::MASK_FULL;
        clk_out_cfg_pkg::IDX_OUT4_PHASE_STRENGTH:
          out4_phase_strength <= wr_byte & clk_out_cfg_pkg::MASK_PHASE_STR;
        clk_out_cfg_pkg::IDX_OUT4_DELAY_COARSE:
          out4_delay_coarse <= wr_byte & clk_out_cfg_pkg::MASK_FULL;
        default:
          out4_delay_coarse <= out4_delay_coarse;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // decoding
  //----------------------------------------------------------------------------
  logic        next_true_leg;
  logic        next_comp_leg;
  logic [5:0]  next_coarse;
  logic [2:0]  next_fine;
  logic [6:0]  next_fine_ps;
  logic [3:0]  term_code;
  logic [3:0]  next_term;
  logic [1:0]  phase_code;

  assign phase_code = out4_phase_strength[clk_out_cfg_pkg::PH_SEL_LSB +: 2];

  leg_phase_router leg_phase_router_inst (
    .phase_sel             (phase_code),
    .single_ended_true_leg (next_true_leg),
    .single_ended_comp_leg (next_comp_leg)
  );

  skew_decoder skew_decoder_inst (
    .output_skew_code (out4_delay_coarse),
    .fine_extend      (out3_format_cfg[clk_out_cfg_pkg::FMT_FINE_EXT]),
    .coarse_periods   (next_coarse),
    .fine_steps       (next_fine),
    .fine_delay_ps    (next_fine_ps)
  );

  // unlisted termination codes fall back to external termination so the
  // driver never sees a mixed pull and single-ended request
  assign term_code = out3_termination_cfg[3:0];
  always_comb
  begin
    unique case (term_code)
      clk_out_cfg_pkg::TERM_PULL_UP:   next_term = 4'h1; // see [R11]
      clk_out_cfg_pkg::TERM_PULL_DOWN: next_term = 4'h2; // see [R11]
      clk_out_cfg_pkg::TERM_SE_TRUE:   next_term = 4'h4; // see [R11]
      clk_out_cfg_pkg::TERM_SE_COMP:   next_term = 4'h8; // see [R11]
      clk_out_cfg_pkg::TERM_SE_BOTH:   next_term = 4'hc; // see [R11]
      default:                         next_term = 4'h0; // see [R12]
    endcase
  end

  //----------------------------------------------------------------------------
  // registered settings
  //----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      output_standard_sel <= 3'h0;
      output_supply_sel   <= 2'h0;
      fuse_written        <= 1'b0;
    end
    else
    begin
      output_standard_sel <=
        out3_format_cfg[clk_out_cfg_pkg::FMT_STD_LSB +: 3]; // see [R9]
      output_supply_sel   <=
        out3_format_cfg[clk_out_cfg_pkg::FMT_SUPPLY_LSB +: 2]; // see [R8]
      fuse_written        <=
        ^out3_format_cfg[clk_out_cfg_pkg::FMT_MARKER_LSB +: 2]; // see [R10]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      term_pull_up   <= 1'b0;
      term_pull_down <= 1'b0;
      se_true_en     <= 1'b0;
      se_comp_en     <= 1'b0;
    end
    else
    begin
      term_pull_up   <= next_term[0]; // see [R11]
      term_pull_down <= next_term[1];
      se_true_en     <= next_term[2];
      se_comp_en     <= next_term[3];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      output_divider <= 20'h0_0000;
    else
      output_divider <= {out4_divider_top[3:0], out4_divider_mid,
                         out4_divider_low}; // see [R1]
  end

  // strength is passed as written; the recommended value is software's job
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      single_ended_true_leg <= 1'b0;
      single_ended_comp_leg <= 1'b1;
      se_drive_strength     <= 3'h0;
    end
    else
    begin
      single_ended_true_leg <= next_true_leg; // see [R2]
      single_ended_comp_leg <= next_comp_leg;
      se_drive_strength     <=
        out4_phase_strength[clk_out_cfg_pkg::PH_STR_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      coarse_periods <= 6'h00;
      fine_steps     <= 3'h0;
      fine_delay_ps  <= 7'h00;
    end
    else
    begin
      coarse_periods <= next_coarse; // see [R4] see [R5]
      fine_steps     <= next_fine; // see [R6] see [R7]
      fine_delay_ps  <= next_fine_ps;
    end
  end

  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic wr_div_low;
  assign wr_div_low = wr_commit &&
    (reg_idx == clk_out_cfg_pkg::IDX_OUT4_DIVIDER_LOW);

  a_divider_concat: assert property ( // see [R1]
    wr_div_low |-> ##2 output_divider[7:0] == $past(pwdata[7:0], 2))
    else $error("divider low byte not reflected two cycles after write");

  a_divider_order: assert property ( // see [R1]
    ##1 output_divider == {$past(out4_divider_top[3:0]),
      $past(out4_divider_mid), $past(out4_divider_low)})
    else $error("divider parts out of order");

  a_phase_route: assert property ( // see [R2]
    ##1 single_ended_true_leg == $past(out4_phase_strength[7]) &&
      single_ended_comp_leg == !$past(out4_phase_strength[6]))
    else $error("leg routing does not follow phase code");

  a_coarse_value: assert property ( // see [R5]
    ##1 coarse_periods == $past(out4_delay_coarse[5:0]))
    else $error("coarse delay differs from code");

  a_fine_plain: assert property ( // see [R6]
    !out3_format_cfg[4] |=> fine_steps == $past(out4_delay_coarse[7:6]) &&
      fine_delay_ps == 7'(fine_steps * 30))
    else $error("fine delay wrong without extension");

  a_fine_extend: assert property ( // see [R7]
    out3_format_cfg[4] |=> fine_steps == 3'h4)
    else $error("extended fine delay not four steps");

  a_supply_field: assert property ( // see [R8]
    ##1 output_supply_sel == $past(out3_format_cfg[4:3]))
    else $error("supply selection not taken from bits 4:3");

  a_standard_field: assert property ( // see [R9]
    ##1 output_standard_sel == $past(out3_format_cfg[2:0]))
    else $error("driver standard not taken from bits 2:0");

  a_fuse_marker: assert property ( // see [R10]
    ##1 fuse_written == ($past(out3_format_cfg[7:6]) inside {2'h1, 2'h2}))
    else $error("fuse marker decode wrong");

  a_term_exclusive: assert property ( // see [R11]
    !((term_pull_up || term_pull_down) && (se_true_en || se_comp_en)))
    else $error("pull and single-ended modes both active");

  a_term_se_both: assert property ( // see [R11]
    term_code == 4'hc |=> se_true_en && se_comp_en && !term_pull_up)
    else $error("single-ended both legs not decoded");

  a_apb_answer: assert property (
    setup_phase |=> pready ##1 !pready)
    else $error("access phase not answered in one cycle");

  a_unmapped_err: assert property (
    setup_phase && !hit |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");

  c_write_divider: cover property (wr_div_low);
  c_fine_extended: cover property (out3_format_cfg[4] ##1 fine_steps == 3'h4);
  c_fuse_written:  cover property ($rose(fuse_written));
  c_unmapped:      cover property (pslverr && pready);

endmodule // clk_out_cfg_regs
`default_nettype wire

// [dv/clk_out_cfg_regs_tb.sv]
// self-checking bench for the clock output configuration register bank
`timescale 1ns/1ns
`default_nettype none
module clk_out_cfg_regs_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  output_standard_sel;
  logic [1:0]  output_supply_sel;
  logic        fuse_written;
  logic        term_pull_up;
  logic        term_pull_down;
  logic        se_true_en;
  logic        se_comp_en;
  logic [19:0] output_divider;
  logic        single_ended_true_leg;
  logic        single_ended_comp_leg;
  logic [2:0]  se_drive_strength;
  logic [5:0]  coarse_periods;
  logic [2:0]  fine_steps;
  logic [6:0]  fine_delay_ps;
  logic [50:0] seen_dec;
  logic [50:0] dec_note;
  logic [33:0] bus_note;
  logic [33:0] bus_q [$];
  logic [50:0] dec_q [$];
  logic [7:0]  shadow [0:7];
  logic [7:0]  regs [0:6];
  logic [3:0]  terms [0:5];
  logic [31:0] seed;
  int          mismatches;
  int          compares;
  event        dec_ev;

  clk_out_cfg_regs clk_out_cfg_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .output_standard_sel(output_standard_sel),
    .output_supply_sel(output_supply_sel), .fuse_written(fuse_written),
    .term_pull_up(term_pull_up), .term_pull_down(term_pull_down),
    .se_true_en(se_true_en), .se_comp_en(se_comp_en),
    .output_divider(output_divider),
    .single_ended_true_leg(single_ended_true_leg),
    .single_ended_comp_leg(single_ended_comp_leg),
    .se_drive_strength(se_drive_strength),
    .coarse_periods(coarse_periods), .fine_steps(fine_steps),
    .fine_delay_ps(fine_delay_ps)
  );

  assign seen_dec = {output_standard_sel, output_supply_sel, fuse_written,
                     term_pull_up, term_pull_down, se_true_en, se_comp_en,
                     output_divider, single_ended_true_leg,
                     single_ended_comp_leg, se_drive_strength,
                     coarse_periods, fine_steps, fine_delay_ps};

  always #10 pclk = ~pclk;

  //----------------------------------------------------------------------------
  // reference model
  //----------------------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // {mapped, writable mask}; unmapped or unaligned gives zero
  function automatic logic [8:0] slot(input logic [7:0] a);
    case (a)
      8'hb4:                return {1'b1, clk_out_cfg_pkg::MASK_FORMAT};
      8'hbc:                return {1'b1, clk_out_cfg_pkg::MASK_TERMINATION};
      8'hc0:                return {1'b1, clk_out_cfg_pkg::MASK_DIVIDER_TOP};
      8'hc4, 8'hc8, 8'hd0:  return {1'b1, clk_out_cfg_pkg::MASK_FULL};
      8'hcc:                return {1'b1, clk_out_cfg_pkg::MASK_PHASE_STR};
      default:              return 9'h000;
    endcase
  endfunction

  function automatic logic [50:0] expect_dec();
    logic [7:0] f;
    logic [7:0] t;
    logic [7:0] ph;
    logic [7:0] d;
    logic [2:0] fine;
    f = shadow[0];
    t = shadow[2];
    ph = shadow[6];
    d = shadow[7];
    // extension saturates at four steps
    fine = f[4] ? clk_out_cfg_pkg::FINE_STEPS_MAX : {1'b0, d[7:6]};
    return {f[2:0], f[4:3], f[7] ^ f[6],
            t == {4'h0, clk_out_cfg_pkg::TERM_PULL_UP},
            t == {4'h0, clk_out_cfg_pkg::TERM_PULL_DOWN},
            t == 8'h04 || t == 8'h0c, t == 8'h08 || t == 8'h0c,
            shadow[3][3:0], shadow[4], shadow[5], ph[7], ~ph[6], ph[2:0],
            d[5:0], fine, 7'(fine * clk_out_cfg_pkg::FINE_STEP_PS)};
  endfunction

  //----------------------------------------------------------------------------
  // apb master and result notes
  //----------------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, input logic [3:0] st);
    logic [8:0]  s;
    logic [31:0] rd;
    int          idx;
    s = slot(a);
    idx = int'(8'(a - 8'hb4) >> 2) & 7;
    rd = s[8] ? {24'h0, shadow[idx]} : 32'h0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    bus_q.push_back({~wr, ~s[8], rd});
    if (wr && s[8] && st[0])
      shadow[idx] = wd[7:0] & s[7:0];
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check_dec();
    @(posedge pclk);
    @(negedge pclk);
    dec_q.push_back(expect_dec());
    -> dec_ev;
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    seed = xorshift(seed);
    apb(1'b1, a, d, {seed[3:1], 1'b1});
    check_dec();
  endtask

  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      bus_note = bus_q.pop_front();
      compares++;
      if (pslverr !== bus_note[32])
      begin
        mismatches++;
        $display("Error pslverr expected %b seen %b", bus_note[32], pslverr);
      end
      if (bus_note[33])
      begin
        compares++;
        if (prdata !== bus_note[31:0])
        begin
          mismatches++;
          $display("Error prdata expected %h seen %h", bus_note[31:0], prdata);
        end
      end
    end
  end

  always @(dec_ev)
  begin
    dec_note = dec_q.pop_front();
    compares++;
    if (seen_dec !== dec_note)
    begin
      mismatches++;
      $display("Error decoded expected %h seen %h", dec_note, seen_dec);
    end
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    tally_and_finish();
  end

  //----------------------------------------------------------------------------
  // scenarios
  //----------------------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    seed = 32'heaca;
    mismatches = 0;
    compares = 0;
    regs = '{8'hb4, 8'hbc, 8'hc0, 8'hc4, 8'hc8, 8'hcc, 8'hd0};
    terms = '{clk_out_cfg_pkg::TERM_EXTERNAL, clk_out_cfg_pkg::TERM_PULL_UP,
              clk_out_cfg_pkg::TERM_PULL_DOWN, clk_out_cfg_pkg::TERM_SE_TRUE,
              clk_out_cfg_pkg::TERM_SE_COMP, clk_out_cfg_pkg::TERM_SE_BOTH};
    for (int i = 0; i < 8; i++)
      shadow[i] = 8'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check_dec();
    for (int i = 0; i < 7; i++)
      apb(1'b0, regs[i], 32'h0, 4'h0);
    // reserved bits set must read back zero; low byte keeps listed codes
    for (int i = 0; i < 7; i++)
    begin
      wrc(regs[i], 32'hfffffff4);
      apb(1'b0, regs[i], 32'h0, 4'h0);
    end
    for (int i = 0; i < 6; i++)
      wrc(8'hb4, {24'h0, 2'(i), 1'b0, 2'(i % 3),
                  3'(i)});
    for (int i = 0; i < 6; i++)
      wrc(8'hbc, {28'h0, terms[i]});
    repeat (3)
    begin
      seed = xorshift(seed);
      wrc(8'hc0, seed);
      wrc(8'hc4, seed >> 8);
      wrc(8'hc8, seed >> 16);
    end
    for (int i = 0; i < 4; i++)
      wrc(8'hcc, {24'h0, 2'(i), seed[5:3],
                  clk_out_cfg_pkg::STRENGTH_RECOMMENDED});
    for (int i = 0; i < 16; i++)
    begin
      wrc(8'hb4, {27'h0, i[3], 4'h0});
      wrc(8'hd0, {24'h0, 2'(i),
                  i[2] ? 6'h3f : 6'h00});
    end
    apb(1'b1, 8'hb8, 32'hff, 4'hf);
    apb(1'b0, 8'hb8, 32'h0, 4'h0);
    apb(1'b1, 8'hc1, 32'hff, 4'hf);
    apb(1'b0, 8'hc1, 32'h0, 4'h0);
    apb(1'b1, 8'hc4, 32'h5a, 4'he);
    apb(1'b0, 8'hc4, 32'h0, 4'h0);
    check_dec();
    // a reset in mid-run must bring registers and outputs back to reset values
    @(posedge pclk);
    presetn <= 1'b0;
    for (int i = 0; i < 8; i++)
      shadow[i] = 8'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check_dec();
    apb(1'b0, 8'hd0, 32'h0, 4'h0);
    apb(1'b0, 8'hb4, 32'h0, 4'h0);
    tally_and_finish();
  end
endmodule // clk_out_cfg_regs_tb
`default_nettype wire
